// ---- hdl/pulse_mod_map.vh ----
// Constants for the pulse modulation generator
`ifndef PULSE_MOD_MAP_VH
`define PULSE_MOD_MAP_VH

// Timebase
`define CLK_PERIOD_PS     5000
`define TIMEBASE_PS       20000
`define TICK_CYCLES       (`TIMEBASE_PS / `CLK_PERIOD_PS)
`define TICK_CNT_W        2

// Field widths in 20 ns ticks
`define TIME_W            26
`define PERIOD_W          33

// Trigger mode encodings
`define TRIG_MODE_W       2
`define TRIG_MODE_AUTO    2'h0
`define TRIG_MODE_EXT     2'h1
`define TRIG_MODE_GATED   2'h2

// Reset values, in 20 ns ticks
`define RST_WIDTH         26'h000c350
`define RST_DELAY         26'h0000001
`define RST_PERIOD        33'h00000c350
`define RST_DBL_DELAY     26'h000c350
`define RST_DBL_WIDTH     26'h000c350
`define RST_TRIG_MODE     `TRIG_MODE_AUTO
`define RST_SLOPE_NEG     1'b0
`define RST_GATE_INV      1'b0
`define RST_POL_INV       1'b0
`define RST_DBL_EN        1'b0

`endif

// ---- hdl/ext_pulse_conditioner.v ----
// Synchroniser and edge/level detector for the external pulse input
`timescale 1ns/1ps
`default_nettype none

module ext_pulse_conditioner (
    input  wire ref_clk_in,         // System clock
    input  wire rstn_in,            // Async reset, active low
    input  wire ext_pulse_in,       // Asynchronous external pulse pin
    input  wire slope_neg_in,       // 1: falling edge triggers
    input  wire gate_inv_in,        // 1: gate active while low
    output wire trig_edge_out,      // One-cycle pulse on selected edge
    output wire gate_active_out     // Gate level after polarity
);

    reg meta_ff;
    reg sync_ff;
    reg prev_ff;

    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= ext_pulse_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Only the second and third stages feed detection
    assign trig_edge_out   = slope_neg_in ? (prev_ff & ~sync_ff)
                                          : (~prev_ff & sync_ff);
    assign gate_active_out = sync_ff ^ gate_inv_in;

endmodule

`default_nettype wire

// ---- hdl/pulse_mod_unit.v ----
// Pulse modulation generator with trigger, gate and double pulse
`timescale 1ns/1ps
`default_nettype none

`include "pulse_mod_map.vh"

// Behaviour
// - Enabling modulation starts generator and video/sync output; off after reset. pulse_mod_en_in is not reset, so auto mode runs at once if it is high.
// - Video/sync output can be switched off while modulation stays enabled.
// - Trigger reacts on rising or falling edge as set; rising after reset.
// - Gated mode pulses only while gate high, or low if inverted.
// - Auto mode, the reset mode, runs the pulse train continuously.
// - External mode starts generation on a trigger event on the input.
// - Gated mode generates only while the gate on the input is active.
// - Width 20 ns to 1 s in 20 ns steps; 1 ms after reset.
// - Programmed delay after trigger before first pulse; not in double mode.
// - Pulse repeats at the programmed period; external mode runs one period per trigger.
// - Normal polarity blanks RF in pause; inverted blanks during pulse.
// - Double mode gives two pulses in each period.
module pulse_mod_unit (
    input  wire                    ref_clk_in,        // 200 MHz clock
    input  wire                    rstn_in,           // Async reset, low
    input  wire                    pulse_mod_en_in,   // Modulation enable
    input  wire                    video_off_in,      // Video/sync forced off
    input  wire                    cfg_load_in,       // Load settings pulse
    input  wire [`TRIG_MODE_W-1:0] trig_mode_in,      // Auto/ext/gated
    input  wire                    slope_neg_in,      // Falling edge trigger
    input  wire                    gate_inv_in,       // Inverted gate
    input  wire                    pol_inv_in,        // Inverted RF polarity
    input  wire                    dbl_en_in,         // Double pulse enable
    input  wire [`TIME_W-1:0]      width_in,          // Width, ticks
    input  wire [`TIME_W-1:0]      delay_in,          // Delay, ticks
    input  wire [`PERIOD_W-1:0]    period_in,         // Period, ticks
    input  wire [`TIME_W-1:0]      dbl_delay_in,      // 2nd pulse start
    input  wire [`TIME_W-1:0]      dbl_width_in,      // 2nd pulse width
    input  wire                    external_pulse_in, // External trig/gate
    output reg                     rf_enable_out,     // RF on when high
    output reg                     video_sync_out,    // Video/sync signal
    output wire                    running_out        // Generator active
);

    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_DELAY = 3'b010;
    localparam [2:0] ST_RUN   = 3'b100;

    reg [`TRIG_MODE_W-1:0] mode_ff;
    reg                    slope_neg_ff;
    reg                    gate_inv_ff;
    reg                    pol_inv_ff;
    reg                    dbl_en_ff;
    reg [`TIME_W-1:0]      width_ff;
    reg [`TIME_W-1:0]      delay_ff;
    reg [`PERIOD_W-1:0]    period_ff;
    reg [`TIME_W-1:0]      dbl_delay_ff;
    reg [`TIME_W-1:0]      dbl_width_ff;

    reg [`TICK_CNT_W-1:0]  tick_cnt_ff;
    reg [2:0]              state_ff;
    reg [2:0]              nxt_state;
    reg [`PERIOD_W-1:0]    phase_ff;
    reg [`PERIOD_W-1:0]    nxt_phase;
    reg                    nxt_rf_enable;
    reg                    nxt_video_sync;

    wire tick;
    wire trig_edge;
    wire gate_active;
    wire pulse_on;
    wire pulse1;
    wire pulse2;
    wire period_end;
    wire [`PERIOD_W-1:0]   dbl_end;

    localparam integer           TICK_LAST_I = `TICK_CYCLES - 1;
    localparam [`TICK_CNT_W-1:0] TICK_LAST   = TICK_LAST_I[`TICK_CNT_W-1:0];

    ext_pulse_conditioner u_cond (
        .ref_clk_in      (ref_clk_in),
        .rstn_in         (rstn_in),
        .ext_pulse_in    (external_pulse_in),
        .slope_neg_in    (slope_neg_ff),
        .gate_inv_in     (gate_inv_ff),
        .trig_edge_out   (trig_edge),
        .gate_active_out (gate_active)
    );

    // Settings keep their reset defaults until the host loads new ones
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_ff      <= `RST_TRIG_MODE;
            slope_neg_ff <= `RST_SLOPE_NEG;
            gate_inv_ff  <= `RST_GATE_INV;
            pol_inv_ff   <= `RST_POL_INV;
            dbl_en_ff    <= `RST_DBL_EN;
            width_ff     <= `RST_WIDTH;
            delay_ff     <= `RST_DELAY;
            period_ff    <= `RST_PERIOD;
            dbl_delay_ff <= `RST_DBL_DELAY;
            dbl_width_ff <= `RST_DBL_WIDTH;
        end else if (cfg_load_in) begin
            mode_ff      <= trig_mode_in;
            slope_neg_ff <= slope_neg_in;
            gate_inv_ff  <= gate_inv_in;
            pol_inv_ff   <= pol_inv_in;
            dbl_en_ff    <= dbl_en_in;
            width_ff     <= width_in;
            delay_ff     <= delay_in;
            period_ff    <= period_in;
            dbl_delay_ff <= dbl_delay_in;
            dbl_width_ff <= dbl_width_in;
        end
    end

    // Common 20 ns timebase
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_cnt_ff <= {`TICK_CNT_W{1'b0}};
        end else if (tick) begin
            tick_cnt_ff <= {`TICK_CNT_W{1'b0}};
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
        end
    end
    assign tick = (tick_cnt_ff == TICK_LAST);

    // Phase within the period; width above period is the host's problem
    assign pulse1     = (phase_ff < {7'h00, width_ff});
    assign dbl_end    = {7'h00, dbl_delay_ff} + {7'h00, dbl_width_ff};
    assign pulse2     = dbl_en_ff
                        && (phase_ff >= {7'h00, dbl_delay_ff})
                        && (phase_ff < dbl_end);
    assign period_end = tick && (phase_ff >= period_ff - 1'b1);
    assign pulse_on   = (state_ff == ST_RUN) && (pulse1 || pulse2);

    always @* begin
        nxt_state = state_ff;
        nxt_phase = phase_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_phase = {`PERIOD_W{1'b0}};
                if (pulse_mod_en_in) begin
                    case (mode_ff)
                        `TRIG_MODE_AUTO: begin
                            nxt_state = ST_RUN;
                        end
                        `TRIG_MODE_EXT: begin
                            if (trig_edge) begin
                                nxt_state = dbl_en_ff ? ST_RUN
                                                      : ST_DELAY;
                            end
                        end
                        `TRIG_MODE_GATED: begin
                            if (gate_active) begin
                                nxt_state = ST_RUN;
                            end
                        end
                        default: begin
                            nxt_state = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_DELAY: begin
                if (tick) begin
                    nxt_phase = phase_ff + 1'b1;
                    // Delay of 0 ends on the first tick instead of wrapping
                    if (phase_ff + 1'b1 >= {7'h00, delay_ff}) begin
                        nxt_state = ST_RUN;
                        nxt_phase = {`PERIOD_W{1'b0}};
                    end
                end
            end
            ST_RUN: begin
                if (tick) begin
                    nxt_phase = phase_ff + 1'b1;
                end
                if (period_end) begin
                    nxt_phase = {`PERIOD_W{1'b0}};
                    // One period per external trigger, then rearm
                    if (mode_ff == `TRIG_MODE_EXT) begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_phase = {`PERIOD_W{1'b0}};
            end
        endcase
        // Gate dropping cuts the train at once, not at period end
        if ((mode_ff == `TRIG_MODE_GATED) && !gate_active) begin
            nxt_state = ST_IDLE;
            nxt_phase = {`PERIOD_W{1'b0}};
        end
        if (!pulse_mod_en_in) begin
            nxt_state = ST_IDLE;
            nxt_phase = {`PERIOD_W{1'b0}};
        end
    end

    always @* begin
        // Without modulation the RF path is simply on
        if (!pulse_mod_en_in) begin
            nxt_rf_enable = 1'b1;
        end else begin
            nxt_rf_enable = pulse_on ^ pol_inv_ff;
        end
        nxt_video_sync = pulse_mod_en_in && !video_off_in
                         && pulse_on;
    end

    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff       <= ST_IDLE;
            phase_ff       <= {`PERIOD_W{1'b0}};
            rf_enable_out  <= 1'b1;
            video_sync_out <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            phase_ff       <= nxt_phase;
            rf_enable_out  <= nxt_rf_enable;
            video_sync_out <= nxt_video_sync;
        end
    end

    assign running_out = (state_ff == ST_RUN);

endmodule

`default_nettype wire

// ---- tb/pulse_mod_unit_properties.sv ----
// Concurrent checks on the pulse modulation generator ports
`timescale 1ns/1ps
`default_nettype none
`include "pulse_mod_map.vh"
module pulse_mod_checks (
    input wire logic                    ref_clk_in,        // Clock
    input wire logic                    rstn_in,           // Reset, low
    input wire logic                    pulse_mod_en_in,   // Enable
    input wire logic                    video_off_in,      // Video off
    input wire logic                    cfg_load_in,       // Load strobe
    input wire logic [`TRIG_MODE_W-1:0] trig_mode_in,      // Mode
    input wire logic                    slope_neg_in,      // Falling edge
    input wire logic                    gate_inv_in,       // Gate inverted
    input wire logic                    pol_inv_in,        // RF inverted
    input wire logic                    dbl_en_in,         // Double pulse
    input wire logic [`TIME_W-1:0]      width_in,          // Width
    input wire logic [`TIME_W-1:0]      delay_in,          // Delay
    input wire logic [`PERIOD_W-1:0]    period_in,         // Period
    input wire logic [`TIME_W-1:0]      dbl_delay_in,      // 2nd start
    input wire logic [`TIME_W-1:0]      dbl_width_in,      // 2nd width
    input wire logic                    external_pulse_in, // Pin
    input wire logic                    rf_enable_out,     // RF on
    input wire logic                    video_sync_out,    // Video
    input wire logic                    running_out        // Active
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    // Settings as the design holds them; ports may differ between loads
    logic [`TRIG_MODE_W-1:0] seen_mode_ff;
    logic                    seen_ginv_ff;
    logic                    seen_pol_ff;
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            seen_mode_ff <= `RST_TRIG_MODE;
            seen_ginv_ff <= `RST_GATE_INV;
            seen_pol_ff  <= `RST_POL_INV;
        end else if (cfg_load_in) begin
            seen_mode_ff <= trig_mode_in;
            seen_ginv_ff <= gate_inv_in;
            seen_pol_ff  <= pol_inv_in;
        end
    end
    a_idle_rf_on: assert property (
        !pulse_mod_en_in [*2] |=> rf_enable_out)
        else $error("RF blanked while modulation off");
    a_idle_stop: assert property (
        !pulse_mod_en_in [*2] |-> !running_out)
        else $error("Generator runs while modulation off");
    // Previous sample taken in reset says nothing about the outputs
    a_video_gate: assert property (
        video_sync_out |-> $past(rstn_in && pulse_mod_en_in && !video_off_in))
        else $error("Video active without enable");
    a_video_off: assert property (
        video_off_in [*2] |=> !video_sync_out)
        else $error("Video high while switched off");
    a_auto_start: assert property (
        seen_mode_ff == `TRIG_MODE_AUTO && $rose(pulse_mod_en_in)
        |=> running_out)
        else $error("Auto mode did not start at once");
    a_pol_normal: assert property (
        !$past(seen_pol_ff)
        && $past(rstn_in && pulse_mod_en_in && !video_off_in)
        |-> rf_enable_out == video_sync_out)
        else $error("RF not on during pulse");
    a_pol_inverted: assert property (
        $past(seen_pol_ff)
        && $past(rstn_in && pulse_mod_en_in && !video_off_in)
        |-> rf_enable_out != video_sync_out)
        else $error("RF not blanked during pulse");
    a_gate_stop: assert property (
        (seen_mode_ff == `TRIG_MODE_GATED && pulse_mod_en_in && !cfg_load_in
         && external_pulse_in == seen_ginv_ff) [*5]
        |=> !running_out)
        else $error("Runs with gate inactive");
    cover property ($rose(running_out));
    cover property (video_off_in && running_out);
    cover property (pol_inv_in && video_sync_out);
endmodule
bind pulse_mod_unit pulse_mod_checks pulse_mod_checks_i (.*);
`default_nettype wire

// ---- tb/pulse_source.sv ----
// Behavioural source of the external trigger and gate pin
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
    input  wire logic ref_clk_in, // Clock for timing only
    output var  logic pin_out     // External pulse pin
);
    initial pin_out = 1'b0;
    // Edges land just after a falling edge, unrelated to the tick phase
    task automatic drive(input logic lvl);
        @(negedge ref_clk_in);
        pin_out = lvl;
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the pulse modulation generator
`timescale 1ns/1ps
`default_nettype none
`include "pulse_mod_map.vh"
module testbench;
    logic                    ref_clk_in, rstn_in, cfg_load_in;
    logic                    pulse_mod_en_in, video_off_in;
    logic [`TRIG_MODE_W-1:0] trig_mode_in;
    logic                    slope_neg_in, gate_inv_in, pol_inv_in, dbl_en_in;
    logic [`TIME_W-1:0]      width_in, delay_in, dbl_delay_in, dbl_width_in;
    logic [`PERIOD_W-1:0]    period_in;
    logic                    external_pulse_in;
    logic                    rf_enable_out, video_sync_out, running_out;
    int                      fail_count = 0;
    int                      compares = 0;
    int                      n, h, l, i;
    pulse_mod_unit pulse_mod_unit_i (.*);
    pulse_source pulse_source_i (.ref_clk_in(ref_clk_in),
        .pin_out(external_pulse_in));
    initial begin
        ref_clk_in = 0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    task automatic give_verdict;
        if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    // Settings only change with modulation off, so stale values never run
    task automatic load(logic [1:0] m, logic s, logic g, logic p, logic d);
        @(negedge ref_clk_in);
        pulse_mod_en_in = 0;
        trig_mode_in = m;
        slope_neg_in = s;
        gate_inv_in = g;
        pol_inv_in = p;
        dbl_en_in = d;
        cfg_load_in = 1;
        @(negedge ref_clk_in);
        cfg_load_in = 0;
    endtask
    task automatic vwait(logic v, output int c);
        c = 0;
        while (video_sync_out !== v && c < 100) begin
            @(negedge ref_clk_in);
            c++;
        end
        if (c >= 100) chk("video edge wait", v, video_sync_out);
    endtask
    // Counts how many of 32 samples rf (sel high) or video sits at v
    task automatic level_cnt(logic sel, logic v, output int c);
        c = 0;
        repeat (32) begin
            @(negedge ref_clk_in);
            c += ((sel ? rf_enable_out : video_sync_out) === v);
        end
    endtask
    task automatic auto_run;
        load(`TRIG_MODE_AUTO, 0, 0, 0, 0);
        pulse_mod_en_in = 1;
        vwait(1, n);
        vwait(0, n);
        vwait(1, n);
        vwait(0, h);
        vwait(1, l);
        chk("pulse width cycles", 12, h);
        chk("pulse period cycles", 32, h + l);
        video_off_in = 1;
        level_cnt(0, 1, n);
        chk("video while off", 0, n);
        level_cnt(1, 0, n);
        chk("rf pause while video off", 20, n);
        video_off_in = 0;
    endtask
    task automatic ext_run(logic s);
        load(`TRIG_MODE_EXT, s, 0, 0, 0);
        pulse_source_i.drive(!s);
        // Let the set-up edge pass the synchroniser before arming
        repeat (4) @(negedge ref_clk_in);
        pulse_mod_en_in = 1;
        pulse_source_i.drive(s);
        repeat (30) @(negedge ref_clk_in);
        chk("run after wrong edge", 0, running_out);
        pulse_source_i.drive(!s);
        n = 0;
        while (running_out !== 1'b1 && n < 40) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk("delay then start", 1, n >= 6 && n <= 20);
        repeat (40) @(negedge ref_clk_in);
        chk("idle after period", 0, running_out);
    endtask
    task automatic ext_dbl_run;
        load(`TRIG_MODE_EXT, 0, 0, 0, 1);
        pulse_source_i.drive(0);
        repeat (4) @(negedge ref_clk_in);
        pulse_mod_en_in = 1;
        pulse_source_i.drive(1);
        n = 0;
        while (running_out !== 1'b1 && n < 40) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk("double skips delay", 1, n >= 2 && n <= 4);
        load(2'h3, 0, 0, 0, 0);
        pulse_mod_en_in = 1;
        repeat (10) @(negedge ref_clk_in);
        chk("spare mode idles", 0, running_out);
    endtask
    task automatic reset_run;
        @(negedge ref_clk_in);
        rstn_in = 0;
        repeat (3) @(negedge ref_clk_in);
        chk("rf in mid reset", 1, rf_enable_out);
        chk("video in mid reset", 0, video_sync_out);
        chk("running in mid reset", 0, running_out);
        rstn_in = 1;
        @(negedge ref_clk_in);
        chk("auto after reset", 1, running_out);
        // Default width is far longer than the wait, loaded width is not
        repeat (200) @(negedge ref_clk_in);
        chk("default width", 1, video_sync_out);
        chk("default polarity", 1, rf_enable_out);
    endtask
    task automatic gate_run(logic g);
        load(`TRIG_MODE_GATED, 0, g, 0, 0);
        pulse_source_i.drive(g);
        repeat (4) @(negedge ref_clk_in);
        pulse_mod_en_in = 1;
        repeat (10) @(negedge ref_clk_in);
        chk("run with gate inactive", 0, running_out);
        pulse_source_i.drive(!g);
        repeat (8) @(negedge ref_clk_in);
        chk("run with gate active", 1, running_out);
        pulse_source_i.drive(g);
        repeat (8) @(negedge ref_clk_in);
        chk("stop on gate loss", 0, running_out);
    endtask
    task automatic shape_run(logic p, logic d, logic v, int e);
        load(`TRIG_MODE_AUTO, 0, 0, p, d);
        pulse_mod_en_in = 1;
        repeat (40) @(negedge ref_clk_in);
        level_cnt(1, v, n);
        chk("rf level cycles", e, n);
    endtask
    initial begin
        {rstn_in, cfg_load_in, pulse_mod_en_in, video_off_in} = 0;
        {trig_mode_in, slope_neg_in, gate_inv_in, pol_inv_in, dbl_en_in} = 0;
        width_in = 26'h0000003;
        delay_in = 26'h0000002;
        period_in = 33'h000000008;
        dbl_delay_in = 26'h0000004;
        dbl_width_in = 26'h0000002;
        repeat (3) @(negedge ref_clk_in);
        chk("rf in reset", 1, rf_enable_out);
        chk("video in reset", 0, video_sync_out);
        chk("running in reset", 0, running_out);
        rstn_in = 1;
        auto_run();
        for (i = 0; i < 2; i++) ext_run(i[0]);
        ext_dbl_run();
        for (i = 0; i < 2; i++) gate_run(i[0]);
        shape_run(1, 0, 0, 12);
        shape_run(0, 1, 1, 20);
        reset_run();
        give_verdict();
    end
    initial begin
        #20000;
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
